/* File: logic/clock_select_consts.vh */
// Purpose: Offsets, field positions, reset values and timing for the clock select block
// Assumes: AHB-Lite register access, byte addresses are four times the register index
// Notes: Register indices are kept as printed
`ifndef CLOCK_SELECT_CONSTS_VH
`define CLOCK_SELECT_CONSTS_VH
`define SUPPLY_INDEX 16'hFF00
`define OSC_INDEX 16'hFF01
`define SUPPLY_ADDR 18'h3FC00
`define OSC_ADDR 18'h3FC04
`define LOGIC_SUPPLY_BIT 0
`define FAST_REG_BIT 1
`define SLOW_SRC_BIT 2
`define LCD_SRC_BIT 3
`define FAST_OSC_BIT 2
`define CPU_SEL_BIT 3
`define SUPPLY_RESET 4'h0
`define OSC_RESET 2'h0
`define LOGIC_WAIT_US 2500
`define OSC_WAIT_US 5000
`endif

/* File: logic/clock_select.v */
// Purpose: Supply, regulator and CPU clock source selection with AHB-Lite registers
// Assumes: slow_clk and fast_clk are free running oscillator clocks when enabled
// Notes: CPU clock mux is a glitch-free two-flop handover per source
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "clock_select_consts.vh"
module clock_select
#(
    // Decoded address width and control nibble width
    parameter ADDR_BITS = 18,
    parameter CTRL_BITS = 4
)
(
    // Bus clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Oscillator clocks
    input wire slow_clk,
    input wire fast_clk,
    // Supply and oscillator controls
    output reg logic_supply_select,
    output reg fast_regulator_on,
    output reg slow_regulator_source,
    output reg lcd_regulator_source,
    output reg fast_osc_on,
    output reg cpu_clock_select,
    // CPU clock
    output wire cpu_clk
);
    // Bus capture state
    reg wr_pend_q;
    reg wr_pend_d;
    reg [ADDR_BITS-1:0] wr_addr_q;
    reg [ADDR_BITS-1:0] wr_addr_d;

    // Stored control bits
    reg [CTRL_BITS-1:0] supply_q;
    reg [CTRL_BITS-1:0] supply_d;
    reg [1:0] osc_q;
    reg [1:0] osc_d;

    // Read path
    reg [31:0] rd_d;

    // Clock handover enables
    reg slow_en_q1;
    reg slow_en_q2;
    reg fast_en_q1;
    reg fast_en_q2;

    // Bus qualifiers
    wire take;
    wire [ADDR_BITS-1:0] word_addr;
    wire [CTRL_BITS-1:0] wdata;
    wire fast_ok;

    // Supply register decode
    function is_supply;
        input [ADDR_BITS-1:0] addr;
        begin
            is_supply = (addr == `SUPPLY_ADDR);
        end
    endfunction

    // Oscillator register decode
    function is_osc;
        input [ADDR_BITS-1:0] addr;
        begin
            is_osc = (addr == `OSC_ADDR);
        end
    endfunction

    // Fast path alive: high voltage or oscillator running
    function fast_allowed;
        input logic_sel;
        input osc_on;
        begin
            fast_allowed = logic_sel | osc_on;
        end
    endfunction

    // Read word for an address
    function [31:0] read_word;
        input [ADDR_BITS-1:0] addr;
        input [CTRL_BITS-1:0] supply;
        input [1:0] osc;
        begin
            read_word = 32'h00000000;
            if (is_supply(addr))
            begin
                read_word[3:0] = supply;
            end
            else if (is_osc(addr))
            begin
                read_word[3:0] = {osc[1], osc[0], 2'h0};
            end
        end
    endfunction

    assign take = hsel & hready & htrans[1];
    assign word_addr = haddr[ADDR_BITS-1:0];
    assign wdata = hwdata[CTRL_BITS-1:0];
    assign fast_ok = fast_allowed(supply_q[`LOGIC_SUPPLY_BIT], osc_q[0]);

    // Address phase capture
    always @*
    begin
        wr_pend_d = take & hwrite;
        wr_addr_d = wr_addr_q;
        if (take)
        begin
            wr_addr_d = word_addr;
        end
    end

    // Register write decode
    always @*
    begin
        supply_d = supply_q;
        osc_d = osc_q;
        if (wr_pend_q)
        begin
            if (is_supply(wr_addr_q))
            begin
                supply_d = wdata;
            end
            else if (is_osc(wr_addr_q))
            begin
                osc_d[0] = wdata[`FAST_OSC_BIT];
                osc_d[1] = wdata[`CPU_SEL_BIT] & fast_ok;
            end
        end
    end

    // Capture flops
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= {ADDR_BITS{1'b0}};
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    // Control register flops
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            supply_q <= `SUPPLY_RESET;
            osc_q <= `OSC_RESET;
        end
        else
        begin
            supply_q <= supply_d;
            osc_q <= osc_d;
        end
    end

    // Read data
    always @*
    begin
        rd_d = read_word(word_addr, supply_q, osc_q);
    end

    // Read data flop, loaded in the address phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
        end
        else
        begin
            if (take && !hwrite)
            begin
                hrdata <= rd_d;
            end
        end
    end

    // Zero wait state, always OKAY
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Supply and regulator pins
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            logic_supply_select <= 1'b0;
            fast_regulator_on <= 1'b0;
            slow_regulator_source <= 1'b0;
            lcd_regulator_source <= 1'b0;
        end
        else
        begin
            logic_supply_select <= supply_q[`LOGIC_SUPPLY_BIT];
            fast_regulator_on <= supply_q[`FAST_REG_BIT];
            slow_regulator_source <= supply_q[`SLOW_SRC_BIT];
            lcd_regulator_source <= supply_q[`LCD_SRC_BIT];
        end
    end

    // Oscillator and clock select pins
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fast_osc_on <= 1'b0;
            cpu_clock_select <= 1'b0;
        end
        else
        begin
            fast_osc_on <= osc_q[0];
            cpu_clock_select <= osc_q[1];
        end
    end

    // Glitch-free handover, each enable on its own clock falling edge
    always @(negedge slow_clk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            slow_en_q1 <= 1'b1;
            slow_en_q2 <= 1'b1;
        end
        else
        begin
            slow_en_q1 <= ~osc_q[1] & ~fast_en_q2;
            slow_en_q2 <= slow_en_q1;
        end
    end

    always @(negedge fast_clk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fast_en_q1 <= 1'b0;
            fast_en_q2 <= 1'b0;
        end
        else
        begin
            fast_en_q1 <= osc_q[1] & ~slow_en_q2;
            fast_en_q2 <= fast_en_q1;
        end
    end

    assign cpu_clk = (slow_clk & slow_en_q2) | (fast_clk & fast_en_q2);
endmodule // clock_select

/* File: testbench/clock_select_asserts.sv */
// Purpose: Port checks of the clock select block
// Assumes: One bus master, transfers spaced by the bench
// Notes: Bound to clock_select
`timescale 1ns/1ns
module clock_select_asserts
(
    // Bus side
    input wire hclk, hresetn, hsel, hwrite, hready,
    input wire [31:0] haddr, hwdata, hrdata,
    input wire [1:0] htrans,
    // Controls and clocks
    input wire logic_supply_select, fast_regulator_on, slow_regulator_source,
    input wire lcd_regulator_source, fast_osc_on, cpu_clock_select,
    input wire slow_clk, fast_clk, cpu_clk
);
    reg wr_q;
    reg rd_q;
    reg [17:0] ad_q;
    wire [3:0] sup = {lcd_regulator_source, slow_regulator_source, fast_regulator_on,
        logic_supply_select};
    wire ws = wr_q && ad_q == 18'h3FC00;
    wire wo = wr_q && ad_q == 18'h3FC04;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Data phase tracking
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            ad_q <= 18'h0;
        end
        else
        begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            rd_q <= hsel && hready && htrans[1] && !hwrite;
            ad_q <= haddr[17:0];
        end
    end
    supply_write_a: assert property (ws |=> ##1 sup == $past(hwdata[3:0], 2))
        else $error("supply bits differ from write");
    osc_write_a: assert property (wo |=> ##1 fast_osc_on == $past(hwdata[2], 2))
        else $error("fast oscillator bit differs from write");
    cpu_sel_a: assert property (wo |=> ##1 cpu_clock_select ==
        $past(hwdata[3] && (logic_supply_select || fast_osc_on), 2))
        else $error("cpu select write wrongly taken or dropped");
    osc_read_a: assert property (rd_q && ad_q == 18'h3FC04 |->
        hrdata[3:0] == {cpu_clock_select, fast_osc_on, 2'h0}) else $error("osc readback wrong");
    supply_read_a: assert property (rd_q && ad_q == 18'h3FC00 |-> hrdata[3:0] == sup)
        else $error("supply readback wrong");
    reset_clear_a: assert property ($rose(hresetn) |-> sup == 4'h0 &&
        !fast_osc_on && !cpu_clock_select) else $error("controls not cleared by reset");
    slow_clk_a: assert property (!cpu_clock_select [*8] |-> cpu_clk == slow_clk)
        else $error("cpu clock not slow source");
    fast_clk_a: assert property (cpu_clock_select [*8] |-> cpu_clk == fast_clk)
        else $error("cpu clock not fast source");
endmodule // clock_select_asserts
bind clock_select clock_select_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .hwrite(hwrite), .hready(hready), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata),
    .htrans(htrans), .logic_supply_select(logic_supply_select),
    .fast_regulator_on(fast_regulator_on), .slow_regulator_source(slow_regulator_source),
    .lcd_regulator_source(lcd_regulator_source), .fast_osc_on(fast_osc_on),
    .cpu_clock_select(cpu_clock_select), .slow_clk(slow_clk), .fast_clk(fast_clk),
    .cpu_clk(cpu_clk));

/* File: testbench/clock_select_tb.sv */
// Purpose: Register sequences for the clock select block
// Assumes: Zero wait state slave, oscillator edges off the bus edges
// Notes: Table entry is write flag, address pick, data nibble
`timescale 1ns/1ns
`include "clock_select_consts.vh"
module clock_select_tb;
    logic hclk, hresetn, hsel, hwrite, slow_clk, fast_clk, hreadyout;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [5:0] ctl;
    int bad_count = 0;
    int samples_checked = 0;
    // Waits shortened, hardware keeps no time count
    logic [7:0] seq [21] = '{8'h00, 8'h10, 8'h9F, 8'h14, 8'h8E, 8'h0E, 8'h83, 8'h94, 8'h9C,
        8'h1C, 8'h94, 8'h90, 8'h80, 8'h98, 8'h10, 8'h94, 8'h9C, 8'h1C, 8'hAF, 8'h20, 8'h00};
    // Halver left before high voltage, order kept both ways
    clock_select dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .slow_clk(slow_clk), .fast_clk(fast_clk), .logic_supply_select(ctl[0]),
        .fast_regulator_on(ctl[1]), .slow_regulator_source(ctl[2]),
        .lcd_regulator_source(ctl[3]), .fast_osc_on(ctl[4]), .cpu_clock_select(ctl[5]),
        .cpu_clk());
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin hclk = 0; forever #4 hclk = ~hclk; end
    initial begin slow_clk = 0; #1; forever #6 slow_clk = ~slow_clk; end
    initial begin fast_clk = 0; #1; forever #2 fast_clk = ~fast_clk; end
    initial begin #5000; bad_count++; end_of_test(); end
    initial
    begin
        logic [31:0] r, a;
        hresetn = 0; hsel = 0; hwrite = 0; htrans = 0; hsize = 0; haddr = 0; hwdata = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (seq[i])
        begin
            a = seq[i][5:4] == 0 ? `SUPPLY_ADDR : seq[i][4] ? `OSC_ADDR : 32'h3FC08;
            xfer(seq[i][7], a, {28'h0, seq[i][3:0]}, r);
            if (!seq[i][7])
                chk("read", r, {28'h0, seq[i][3:0]});
            if (!seq[i][7] && seq[i][5:4] != 2'h2)
                chk("pins", seq[i][4] ? {ctl[5:4], 2'h0} : ctl[3:0], seq[i][3:0]);
        end
        end_of_test();
    end
endmodule // clock_select_tb
